/* core/ccs_ctrl.sv */
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
module ccs_ctrl
    import ccs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic rst_pin_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire ccs_rx_frame_t rx_frame,
    input wire logic [NUM_TXB-1:0] tx_done,
    output logic rx_ack,
    output logic [NUM_TXB-1:0] tx_req,
    output ccs_txb_t [NUM_TXB-1:0] tx_buf,
    output ccs_bit_timing_t timing,
    output logic [2:0] op_mode
);
    ccs_bus_st_t bus_st_ff;
    logic hreadyout_ff, hresp_ff, wr_ff, hi_zero_ff;
    logic [7:0] addr_ff;
    logic [31:0] hrdata_ff, rd_data;
    logic pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_rst_ff, soft_rst_ff;
    logic [7:0] ost_cnt_ff;
    logic [2:0] requested_operation_ff, opmode_ff;
    logic [7:0] tcfg1_ff, tcfg2_ff, tcfg3_ff;
    logic [15:0] mask_ff [0:1];
    logic [15:0] filt_ff [0:NUM_FILT-1];
    logic [NUM_FILT-1:0] match, ext_ok;
    logic rx0_full_ff, rx1_full_ff, rx0_ext_ff, rx1_ext_ff;
    logic [2:0] rx0_fh_ff, rx1_fh_ff, nxt_fh1;
    logic [10:0] rx0_id_ff, rx1_id_ff;
    logic rx_ack_ff;
    ccs_txb_t [NUM_TXB-1:0] txb_ff;
    logic [NUM_TXB-1:0] transmit_request_flag_ff;
    logic [6:0] pre_cnt_ff;
    logic [4:0] tq_cnt_ff;
    ccs_bit_timing_t timing_ff;

    // Bus decode; every access takes one wait state so reads see prior writes
    wire acc = hsel & htrans[1] & hready;
    wire wr_stb = (bus_st_ff == BUS_DATA) & wr_ff & hi_zero_ff;
    wire core_rst = sys_rst | pin_rst_ff | soft_rst_ff;
    wire ost_busy = ost_cnt_ff != 8'h00;
    wire cfg_mode = opmode_ff == MODE_CONFIG;
    wire norm_mode = opmode_ff == MODE_NORMAL;
    wire cfg_wr = wr_stb & cfg_mode;
    wire filt_sel = addr_ff >= FILT_OFS && addr_ff < FILT_OFS + 8'(4 * NUM_FILT);
    wire [7:0] filt_rel = addr_ff - FILT_OFS;
    wire [2:0] filt_idx = filt_rel[4:2];
    wire txb_sel = addr_ff >= TXB_OFS && addr_ff < TXB_END;
    wire [7:0] txb_rel = addr_ff - TXB_OFS;
    wire [1:0] txb_idx = txb_rel[5:4];
    wire [1:0] txb_word = txb_rel[3:2];
    wire rx_go = norm_mode & rx_frame.valid;
    wire hit0 = match[0] | match[1];
    wire hit1 = |match[5:2];
    wire take0 = rx_go & hit0 & ~rx0_full_ff;
    wire take1 = rx_go & ~hit0 & hit1 & ~rx1_full_ff;
    wire rx0_clr = wr_stb & addr_ff == RXB0_OFS & hwdata[RX_FULL_BIT];
    wire rx1_clr = wr_stb & addr_ff == RXB1_OFS & hwdata[RX_FULL_BIT];
    wire [5:0] baud_prescaler = tcfg1_ff[BRP_LSB +: 6];
    wire [6:0] pre_top = {baud_prescaler, 1'b1};
    wire [4:0] prop_tq = 5'(tcfg2_ff[PROP_LSB +: 3]) + 5'h01;
    wire [4:0] ps1_tq = 5'(tcfg2_ff[PS1_LSB +: 3]) + 5'h01;
    wire [4:0] ps2_tq = 5'(tcfg3_ff[PS2_LSB +: 3]) + 5'h01;
    wire [4:0] bit_len = 5'h01 + prop_tq + ps1_tq + ps2_tq;
    wire [4:0] samp_idx = prop_tq + ps1_tq;
    wire tq_tick = ~cfg_mode & pre_cnt_ff == pre_top;

    // Bus slave: address phase, then one held data cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_st_ff <= BUS_IDLE;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
            wr_ff <= 1'b0;
            hi_zero_ff <= 1'b0;
            addr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            case (bus_st_ff)
                BUS_IDLE: begin
                    if (acc) begin
                        bus_st_ff <= BUS_DATA;
                        hreadyout_ff <= 1'b0;
                        wr_ff <= hwrite;
                        hi_zero_ff <= haddr[31:8] == 24'h00_0000;
                        addr_ff <= haddr[7:0];
                    end
                end
                BUS_DATA: begin
                    bus_st_ff <= BUS_IDLE;
                    hreadyout_ff <= 1'b1;
                    if (!wr_ff) begin
                        hrdata_ff <= hi_zero_ff ? rd_data : 32'h0000_0000;
                    end
                end
                default: bus_st_ff <= BUS_IDLE;
            endcase
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_data = 32'h0000_0000;
        if (addr_ff == CTRL_OFS) begin
            rd_data[REQUESTED_OPERATION_LSB +: 3] = requested_operation_ff;
        end else if (addr_ff == STAT_OFS) begin
            rd_data[OPMODE_LSB +: 3] = opmode_ff;
            rd_data[OSTBUSY_BIT] = ost_busy;
        end else if (addr_ff == TCFG1_OFS) begin
            rd_data[7:0] = tcfg1_ff;
        end else if (addr_ff == TCFG2_OFS) begin
            rd_data[7:0] = tcfg2_ff;
        end else if (addr_ff == TCFG3_OFS) begin
            rd_data[7:0] = tcfg3_ff;
        end else if (addr_ff == MASK0_OFS || addr_ff == MASK1_OFS) begin
            rd_data[15:0] = mask_ff[addr_ff == MASK1_OFS];
        end else if (addr_ff == RXB0_OFS) begin
            rd_data = {5'h00, rx0_id_ff, 11'h000, rx0_ext_ff, rx0_full_ff, rx0_fh_ff};
        end else if (addr_ff == RXB1_OFS) begin
            rd_data = {5'h00, rx1_id_ff, 11'h000, rx1_ext_ff, rx1_full_ff, rx1_fh_ff};
        end else if (filt_sel) begin
            rd_data[15:0] = filt_ff[filt_idx];
        end else if (txb_sel && txb_word == TXW_ID) begin
            rd_data[15:0] = txb_ff[txb_idx].id;
        end else if (txb_sel && txb_word == TXW_DLC) begin
            rd_data[3:0] = txb_ff[txb_idx].dlc;
        end else if (txb_sel && txb_word == TXW_DATA) begin
            rd_data = txb_ff[txb_idx].data;
        end else if (txb_sel) begin
            rd_data[TRANSMIT_REQUEST_FLAG_BIT] = transmit_request_flag_ff[txb_idx];
        end
    end

    // Reset pin: three stages, a level counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
            pin_s3_ff <= 1'b1;
            pin_rst_ff <= 1'b0;
            soft_rst_ff <= 1'b0;
        end else begin
            pin_s1_ff <= rst_pin_n;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            if (pin_s2_ff == pin_s3_ff) begin
                pin_rst_ff <= ~pin_s3_ff;
            end
            soft_rst_ff <= wr_stb & addr_ff == CTRL_OFS & hwdata[SOFTRST_BIT];
        end
    end

    // Start-up timer restarts on every reset source and holds the mode
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            ost_cnt_ff <= OST_CYC;
        end else if (ost_busy) begin
            ost_cnt_ff <= ost_cnt_ff - 8'h01;
        end
    end

    // Mode request and mode state
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            requested_operation_ff <= MODE_CONFIG;
            opmode_ff <= MODE_CONFIG;
        end else begin
            if (wr_stb && addr_ff == CTRL_OFS) begin
                requested_operation_ff <= hwdata[REQUESTED_OPERATION_LSB +: 3];
            end
            if (!ost_busy) begin
                opmode_ff <= requested_operation_ff;
            end
        end
    end

    // Timing and masks; a write outside configuration mode is dropped
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            tcfg1_ff <= 8'h00;
            tcfg2_ff <= 8'h00;
            tcfg3_ff <= 8'h00;
            mask_ff[0] <= 16'h0000;
            mask_ff[1] <= 16'h0000;
        end else begin
            if (cfg_wr && addr_ff == TCFG1_OFS) tcfg1_ff <= hwdata[7:0];
            if (cfg_wr && addr_ff == TCFG2_OFS) tcfg2_ff <= hwdata[7:0];
            if (cfg_wr && addr_ff == TCFG3_OFS) tcfg3_ff <= hwdata[7:0];
            if (cfg_wr && addr_ff == MASK0_OFS) mask_ff[0] <= hwdata[15:0];
            if (cfg_wr && addr_ff == MASK1_OFS) mask_ff[1] <= hwdata[15:0];
        end
    end

    // Filters 0 and 1 use mask 0; filters 2 to 5 use mask 1
    for (genvar i = 0; i < NUM_FILT; i++) begin : g_filt
        wire [10:0] msk = mask_ff[i >= 2][15:ID_LSB];
        always_ff @(posedge ref_clk) begin
            if (core_rst) begin
                filt_ff[i] <= 16'h0000;
            end else if (cfg_wr && filt_sel && filt_idx == 3'(i)) begin
                filt_ff[i] <= hwdata[15:0];
            end
        end
        assign ext_ok[i] = filt_ff[i][EXT_BIT] == rx_frame.ext;
        assign match[i] = ext_ok[i] & ((filt_ff[i][15:ID_LSB] ^ rx_frame.id_std) & msk) == 11'h000;
    end

    // Lowest matching buffer-one filter wins
    assign nxt_fh1 = match[2] ? 3'h2 : match[3] ? 3'h3 : match[4] ? 3'h4 : 3'h5;

    // Receive buffers; a full buffer drops the frame, a new frame beats a clear
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            rx0_full_ff <= 1'b0;
            rx1_full_ff <= 1'b0;
            rx0_fh_ff <= 3'h0;
            rx1_fh_ff <= 3'h0;
            rx0_ext_ff <= 1'b0;
            rx1_ext_ff <= 1'b0;
            rx0_id_ff <= 11'h000;
            rx1_id_ff <= 11'h000;
            rx_ack_ff <= 1'b0;
        end else begin
            rx_ack_ff <= rx_go;
            if (take0) begin
                rx0_full_ff <= 1'b1;
                rx0_fh_ff <= match[0] ? 3'h0 : 3'h1;
                rx0_ext_ff <= rx_frame.ext;
                rx0_id_ff <= rx_frame.id_std;
            end else if (rx0_clr) begin
                rx0_full_ff <= 1'b0;
            end
            if (take1) begin
                rx1_full_ff <= 1'b1;
                rx1_fh_ff <= nxt_fh1;
                rx1_ext_ff <= rx_frame.ext;
                rx1_id_ff <= rx_frame.id_std;
            end else if (rx1_clr) begin
                rx1_full_ff <= 1'b0;
            end
        end
    end

    // Transmit buffers; loads are refused while a request is pending
    for (genvar t = 0; t < NUM_TXB; t++) begin : g_txb
        wire hit = wr_stb & txb_sel & txb_idx == 2'(t);
        wire set_req = hit & txb_word == TXW_CTL & hwdata[TRANSMIT_REQUEST_FLAG_BIT];
        always_ff @(posedge ref_clk) begin
            if (core_rst) begin
                txb_ff[t] <= '0;
                transmit_request_flag_ff[t] <= 1'b0;
            end else begin
                if (hit && !transmit_request_flag_ff[t] && txb_word == TXW_ID) txb_ff[t].id <= hwdata[15:0];
                if (hit && !transmit_request_flag_ff[t] && txb_word == TXW_DLC) txb_ff[t].dlc <= hwdata[3:0];
                if (hit && !transmit_request_flag_ff[t] && txb_word == TXW_DATA) txb_ff[t].data <= hwdata;
                if (set_req) begin
                    transmit_request_flag_ff[t] <= 1'b1;
                end else if (tx_done[t]) begin
                    transmit_request_flag_ff[t] <= 1'b0;
                end
            end
        end
    end

    // Quantum prescaler and bit segment counter, idle in configuration
    always_ff @(posedge ref_clk) begin
        if (core_rst || cfg_mode) begin
            pre_cnt_ff <= 7'h00;
            tq_cnt_ff <= 5'h00;
            timing_ff <= '0;
        end else begin
            pre_cnt_ff <= tq_tick ? 7'h00 : pre_cnt_ff + 7'h01;
            if (tq_tick) begin
                tq_cnt_ff <= tq_cnt_ff + 5'h01 >= bit_len ? 5'h00 : tq_cnt_ff + 5'h01;
            end
            timing_ff.tq_tick <= tq_tick;
            timing_ff.sample_pt <= tq_tick & tq_cnt_ff == samp_idx;
            timing_ff.bit_start <= tq_tick & tq_cnt_ff + 5'h01 >= bit_len;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign rx_ack = rx_ack_ff;
    assign tx_req = transmit_request_flag_ff;
    assign tx_buf = txb_ff;
    assign timing = timing_ff;
    assign op_mode = opmode_ff;

    // Helper: clocks since the last quantum tick
    logic [7:0] gap_ff;
    always_ff @(posedge ref_clk) begin
        if (core_rst || cfg_mode || tq_tick) gap_ff <= 8'h00;
        else gap_ff <= gap_ff + 8'h01;
    end

    a_reset_config: assert property (@(posedge ref_clk)
        core_rst |=> opmode_ff == MODE_CONFIG && requested_operation_ff == MODE_CONFIG && ost_cnt_ff == OST_CYC)
        else $error("reset did not enter configuration");
    a_ost_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(core_rst) |-> (ost_busy && opmode_ff == MODE_CONFIG) [*8])
        else $error("mode changed during start-up wait");
    a_timing_locked: assert property (@(posedge ref_clk) disable iff (core_rst)
        wr_stb && !cfg_mode |=> $stable(tcfg1_ff) && $stable(tcfg2_ff) && $stable(mask_ff[1]))
        else $error("locked register changed outside configuration");
    a_tq_period: assert property (@(posedge ref_clk) disable iff (core_rst)
        tq_tick && $past(tq_tick) == 1'b0 |-> gap_ff == 8'(pre_top) || $past(cfg_mode))
        else $error("quantum period wrong");
    a_normal_entry: assert property (@(posedge ref_clk) disable iff (core_rst)
        requested_operation_ff == MODE_NORMAL && !ost_busy |=> opmode_ff == MODE_NORMAL)
        else $error("Normal mode not entered");
    a_rx0_first: assert property (@(posedge ref_clk) disable iff (core_rst)
        rx_go && hit0 |=> $stable(rx1_full_ff) || $past(rx1_clr))
        else $error("buffer one took a buffer zero frame");
    a_rx_store: assert property (@(posedge ref_clk) disable iff (core_rst)
        take1 && match[2] |=> rx1_full_ff && rx1_fh_ff == 3'h2)
        else $error("filter hit not reported");
    a_ext_reject: assert property (@(posedge ref_clk) disable iff (core_rst)
        rx_go && rx_frame.ext != filt_ff[0][EXT_BIT] && rx_frame.ext != filt_ff[1][EXT_BIT] && !rx0_clr
        |=> $stable(rx0_full_ff))
        else $error("frame of wrong identifier type stored");
    a_tx_guard: assert property (@(posedge ref_clk) disable iff (core_rst)
        wr_stb && txb_sel && transmit_request_flag_ff[txb_idx] |=> $stable(txb_ff))
        else $error("pending transmit buffer was modified");
    a_bus_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bus_st_ff == BUS_IDLE && acc |=> !hreadyout_ff ##1 hreadyout_ff)
        else $error("bus answer timing wrong");
endmodule

/* inc/ccs_pkg.sv */
package ccs_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] TCFG1_OFS = 8'h08;
    localparam logic [7:0] TCFG2_OFS = 8'h0C;
    localparam logic [7:0] TCFG3_OFS = 8'h10;
    localparam logic [7:0] MASK0_OFS = 8'h14;
    localparam logic [7:0] MASK1_OFS = 8'h18;
    localparam logic [7:0] RXB0_OFS = 8'h1C;
    localparam logic [7:0] RXB1_OFS = 8'h20;
    localparam logic [7:0] FILT_OFS = 8'h40;
    localparam logic [7:0] TXB_OFS = 8'h80;
    localparam logic [7:0] TXB_END = 8'hB0;
    // Counts of entries
    localparam int NUM_FILT = 6;
    localparam int NUM_TXB = 3;
    // Control and status fields
    localparam int REQUESTED_OPERATION_LSB = 0;
    localparam int SOFTRST_BIT = 8;
    localparam int OPMODE_LSB = 0;
    localparam int OSTBUSY_BIT = 4;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_CONFIG = 3'h4;
    // Identifier register layout: id in [15:5], extended enable in bit 3
    localparam int ID_LSB = 5;
    localparam int EXT_BIT = 3;
    // Receive status fields
    localparam int RX_FULL_BIT = 3;
    localparam int RX_EXT_BIT = 4;
    localparam int RX_ID_LSB = 16;
    // Transmit buffer fields, word index inside a buffer
    localparam int TRANSMIT_REQUEST_FLAG_BIT = 3;
    localparam logic [1:0] TXW_ID = 2'h0;
    localparam logic [1:0] TXW_DLC = 2'h1;
    localparam logic [1:0] TXW_DATA = 2'h2;
    localparam logic [1:0] TXW_CTL = 2'h3;
    // Start-up wait, in oscillator cycles; the oscillator is ref_clk
    localparam int OST_OSC_CYC = 128;
    localparam logic [7:0] OST_CYC = 8'(OST_OSC_CYC);
    // Bit timing field positions
    localparam int BRP_LSB = 0;
    localparam int PROP_LSB = 0;
    localparam int PS1_LSB = 3;
    localparam int PS2_LSB = 0;

    typedef enum logic {BUS_IDLE, BUS_DATA} ccs_bus_st_t;

    typedef struct packed {
        logic valid;
        logic ext;
        logic [10:0] id_std;
        logic [17:0] id_ext;
    } ccs_rx_frame_t;

    typedef struct packed {
        logic [15:0] id;
        logic [3:0] dlc;
        logic [31:0] data;
    } ccs_txb_t;

    typedef struct packed {
        logic tq_tick;
        logic sample_pt;
        logic bit_start;
    } ccs_bit_timing_t;
endpackage

/* bench/ccs_engine_model.sv */
`timescale 1ns/10ps
module ccs_engine_model
    import ccs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic send,
    input wire logic send_ext,
    input wire logic [10:0] send_id,
    input wire logic slow,
    input wire logic [NUM_TXB-1:0] tx_req,
    output ccs_rx_frame_t rx_frame,
    output logic [NUM_TXB-1:0] tx_done
);
    int wait_cnt [NUM_TXB];
    logic [NUM_TXB-1:0] fired;
    initial rx_frame = '0;
    initial tx_done = '0;
    // One-cycle frame; id lines toggle outside frames so a stale id never looks fresh
    always @(posedge ref_clk) begin
        if (send) begin
            rx_frame <= {1'b1, send_ext, send_id, 18'h00000};
        end else begin
            rx_frame <= {1'b0, ~rx_frame.ext, ~rx_frame.id_std, ~rx_frame.id_ext};
        end
    end
    // Finish each pending buffer once, promptly or slowly
    always @(posedge ref_clk) begin
        for (int t = 0; t < NUM_TXB; t++) begin
            tx_done[t] <= !sys_rst && tx_req[t] && !fired[t] && wait_cnt[t] == (slow ? 40 : 2);
            if (sys_rst || !tx_req[t]) begin
                wait_cnt[t] <= 0;
                fired[t] <= 1'b0;
            end else if (!fired[t]) begin
                wait_cnt[t] <= wait_cnt[t] + 1;
                if (wait_cnt[t] == (slow ? 40 : 2)) begin
                    fired[t] <= 1'b1;
                end
            end
        end
    end
endmodule

/* bench/can_controller_setup_modes_test.sv */
`timescale 1ns/10ps
module can_controller_setup_modes_test
    import ccs_pkg::*;
;
    logic ref_clk, sys_rst, rst_pin_n, hsel, hwrite, hreadyout, hresp, rx_ack, slow, send, send_ext, rd_chk;
    logic [31:0] haddr, hwdata, hrdata, rdata, d;
    logic [1:0] htrans;
    logic [2:0] op_mode;
    logic [10:0] send_id;
    logic [NUM_TXB-1:0] tx_req, tx_done;
    ccs_txb_t [NUM_TXB-1:0] tx_buf;
    ccs_bit_timing_t timing;
    ccs_rx_frame_t rx_frame;
    logic [31:0] exp_q[$];
    logic [10:0] ids [4] = '{11'h500, 11'h508, 11'h510, 11'h518};
    int n_errors = 0, tests_run = 0, cyc = 0, tq_last = 0, bs_last = 0, tq_per = 0, bs_per = 0, idx;
    int sp_off = 0, sh;

    ccs_ctrl DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_frame(rx_frame), .tx_done(tx_done), .rx_ack(rx_ack),
        .tx_req(tx_req), .tx_buf(tx_buf), .timing(timing), .op_mode(op_mode));
    ccs_engine_model engine (.ref_clk(ref_clk), .sys_rst(sys_rst), .send(send), .send_ext(send_ext),
        .send_id(send_id), .slow(slow), .tx_req(tx_req), .rx_frame(rx_frame), .tx_done(tx_done));

    // 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // One AHB-Lite single word transfer; only the watchdog ends a hung wait
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd, input logic c, input logic [31:0] e);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge ref_clk); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        if (c) exp_q.push_back(e);
        rd_chk <= c;
        do @(posedge ref_clk); while (!hreadyout);
        rdata = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
        rd_chk <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        bus(a, 1'b1, wd, 1'b0, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0, 1'b1, e);
    endtask

    // Frame from the engine; acknowledge lands one clock after the valid pulse
    task automatic frame(input logic ext, input logic [10:0] id, input logic ack);
        send_id <= id;
        send_ext <= ext;
        send <= 1'b1;
        @(posedge ref_clk);
        send <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("rx_ack", {31'h0, ack}, {31'h0, rx_ack});
    endtask

    task automatic wait_tx_idle();
        for (int n = 0; n < 100 && tx_req !== 3'h0; n++) @(posedge ref_clk);
    endtask

    // Read results are compared against the oldest note
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (rd_chk && hreadyout) chk("hrdata", exp_q.pop_front(), hrdata);
        if (timing.tq_tick) begin
            tq_per <= cyc - tq_last;
            tq_last <= cyc;
        end
        if (timing.bit_start) begin
            bs_per <= cyc - bs_last;
            bs_last <= cyc;
        end
        if (timing.sample_pt) sp_off <= cyc - bs_last;
    end

    // Watchdog, far beyond the fewer than a thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        {sys_rst, rst_pin_n, hsel, hwrite, slow, send, send_ext, rd_chk} = 8'hC0;
        {haddr, hwdata, htrans, send_id} = '0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        void'($urandom(32'h0E0FEFF8));
        // Host keeps off the bus until the start-up wait has run out
        repeat (130) @(posedge ref_clk);
        rd(STAT_OFS, 32'h00000004);
        // Bit timing: divide by 16, 1+1+3+3 quanta
        wr(TCFG1_OFS, 32'h07);
        wr(TCFG2_OFS, 32'h90);
        wr(TCFG3_OFS, 32'h02);
        rd(TCFG2_OFS, 32'h90);
        // Buffer zero rejects standard frames, buffer one takes four ids
        wr(MASK0_OFS, 32'hFFE0);
        wr(MASK1_OFS, 32'hFFE0);
        for (int f = 0; f < NUM_FILT; f++) wr(FILT_OFS + 8'(4 * f), f < 2 ? 32'hFFE8 : {16'h0, ids[f - 2], 5'h0});
        frame(1'b0, ids[0], 1'b0);
        wr(CTRL_OFS, 32'h0);
        rd(STAT_OFS, 32'h0);
        chk("op_mode", 32'h0, {29'h0, op_mode});
        // Locked writes in normal mode are dropped
        wr(TCFG1_OFS, 32'h3F);
        wr(FILT_OFS + 8'h08, 32'h0);
        rd(TCFG1_OFS, 32'h07);
        rd(FILT_OFS + 8'h08, 32'hA000);
        repeat (300) @(posedge ref_clk);
        chk("tq_period", 32'd16, tq_per);
        chk("bit_period", 32'd128, bs_per);
        chk("sample_pt", 32'd80, sp_off);
        // Random start, then every id once; hit field names its filter
        sh = $urandom % 4;
        for (int k = 0; k < 4; k++) begin
            idx = (k + sh) % 4;
            frame(1'b0, ids[idx], 1'b1);
            rd(RXB1_OFS, {5'h0, ids[idx], 16'h0008} | (2 + idx));
            wr(RXB1_OFS, 32'h8);
        end
        frame(1'b0, 11'h7FF, 1'b1);
        rd(RXB0_OFS, 32'h0);
        frame(1'b1, 11'h7FF, 1'b1);
        rd(RXB0_OFS, 32'h07FF0018);
        // Transmit load, refused rewrite while pending, retained fields
        wr(TXB_OFS + 8'h10, 32'h1620);
        wr(TXB_OFS + 8'h14, 32'h1);
        d = $urandom;
        wr(TXB_OFS + 8'h18, d);
        slow <= 1'b1;
        wr(TXB_OFS + 8'h1C, 32'h8);
        repeat (2) @(posedge ref_clk);
        chk("tx_req", 32'h2, {29'h0, tx_req});
        wr(TXB_OFS + 8'h18, ~d);
        chk("tx_data", d, tx_buf[1].data);
        wait_tx_idle();
        chk("tx_req", 32'h0, {29'h0, tx_req});
        slow <= 1'b0;
        wr(TXB_OFS + 8'h1C, 32'h8);
        wait_tx_idle();
        chk("tx_id", 32'h1620, {16'h0, tx_buf[1].id});
        chk("tx_dlc", 32'h1, {28'h0, tx_buf[1].dlc});
        // Reset command, then reset pin
        wr(CTRL_OFS, 32'h100);
        repeat (2) @(posedge ref_clk);
        rd(STAT_OFS, 32'h14);
        rd(TCFG1_OFS, 32'h0);
        repeat (130) @(posedge ref_clk);
        wr(MASK1_OFS, 32'h0020);
        rd(MASK1_OFS, 32'h0020);
        wr(CTRL_OFS, 32'h0);
        rst_pin_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_pin_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rd(STAT_OFS, 32'h14);
        rd(MASK1_OFS, 32'h0);
        repeat (4) @(posedge ref_clk);
        tally_and_finish();
    end
endmodule
